// [hdl/swc_ctrl.v]
// Switch control register with reset triggers, lock gating and sticky switch options
`timescale 1ns/1ps
`include "swc_regs.vh"
module swc_ctrl (
  input  wire                   i_clock,
  input  wire                   i_rst,
  input  wire                   i_reg_req,
  input  wire                   i_reg_we,
  input  wire [`SWC_ADDR_W-1:0] i_reg_addr,
  input  wire [31:0]            i_reg_wdata,
  output reg                    o_reg_ack,
  output reg  [31:0]            o_reg_rdata,
  input  wire                   i_warm_rst,
  input  wire                   i_reset_in_progress,
  input  wire                   i_load_error,
  input  wire                   i_upstream_dl_down,
  input  wire                   i_other_warm_cause,
  input  wire                   i_full_reset_ack,
  input  wire                   i_warm_reset_ack,
  output wire                   o_full_reset_req,
  output wire                   o_warm_reset_req,
  output wire                   o_hold_in_reset,
  output wire                   o_write_lock_release,
  output wire                   o_budget_value_write_enable,
  output wire                   o_skip_load_on_warm_reset,
  output wire                   o_force_strict_ordering
);

  // ****************************************
  // Register port decode
  // ****************************************
  wire       hit;
  wire       wr;
  wire [7:0] stored;
  wire [7:0] hw_set;
  reg        dl_down_prev;
  wire       dl_down_edge;
  wire       warm_cause;
  wire       full_cause;

  assign hit = (i_reg_addr == `SWC_SWITCH_CONTROL);
  assign wr  = i_reg_req && i_reg_we && hit;

  // ****************************************
  // Hardware sets
  // ****************************************
  assign hw_set[`SWC_FULL_RESET_BIT] = 1'b0;
  assign hw_set[`SWC_WARM_RESET_BIT] = 1'b0;
  assign hw_set[`SWC_HOLD_BIT]       = i_load_error;
  assign hw_set[`SWC_LOCK_REL_BIT]   = i_reset_in_progress;
  assign hw_set[7:4]                 = 4'h0;

  // ****************************************
  // Stored fields
  // ****************************************
  // Trigger bits 0 and 1 hold no state and always read as zero
  assign stored[`SWC_FULL_RESET_BIT] = 1'b0;
  assign stored[`SWC_WARM_RESET_BIT] = 1'b0;

  genvar g;
  generate
    for (g = `SWC_HOLD_BIT; g <= `SWC_STRICT_BIT; g = g + 1) begin : g_bit
      swc_ctl_bit #(
        .STICKY    ((`SWC_STICKY_MASK >> g) & 1),
        .LOCKED    ((`SWC_LOCKED_MASK >> g) & 1),
        .RESET_VAL (`SWC_CTRL_RESET >> g)
      ) u_bit (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_warm_rst (i_warm_rst),
        .i_wr       (wr),
        .i_wdata    (i_reg_wdata[g]),
        .i_unlock   (stored[`SWC_LOCK_REL_BIT]),
        .i_hw_set   (hw_set[g]),
        .o_q        (stored[g])
      );
    end
  endgenerate

  // ****************************************
  // Reset causes
  // ****************************************
  // The link-down cause is taken on entry to DL_Down, so a link that stays down
  // asks for one hot reset, not one per cycle.
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dl_down_prev <= 1'b0;
    end else begin
      dl_down_prev <= i_upstream_dl_down;
    end
  end

  assign dl_down_edge = i_upstream_dl_down && !dl_down_prev;
  assign full_cause   = wr && i_reg_wdata[`SWC_FULL_RESET_BIT];
  assign warm_cause   = (wr && i_reg_wdata[`SWC_WARM_RESET_BIT])
                      || (dl_down_edge && !stored[`SWC_LD_MASK_BIT])
                      || i_other_warm_cause;

  swc_trigger u_full (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_cause (full_cause),
    .i_ack   (i_full_reset_ack),
    .o_req   (o_full_reset_req)
  );

  swc_trigger u_warm (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_cause (warm_cause),
    .i_ack   (i_warm_reset_ack),
    .o_req   (o_warm_reset_req)
  );

  // ****************************************
  // Control outputs
  // ****************************************
  assign o_hold_in_reset             = stored[`SWC_HOLD_BIT];
  assign o_write_lock_release        = stored[`SWC_LOCK_REL_BIT];
  assign o_budget_value_write_enable = stored[`SWC_BUDGET_WE_BIT];
  assign o_skip_load_on_warm_reset   = stored[`SWC_SKIP_LOAD_BIT];
  assign o_force_strict_ordering     = stored[`SWC_STRICT_BIT];

  // ****************************************
  // Read and acknowledge
  // ****************************************
  // Every request is answered one cycle later; unmapped reads return zero
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_reg_ack   <= 1'b0;
      o_reg_rdata <= 32'h00000000;
    end else begin
      o_reg_ack <= i_reg_req;
      if (i_reg_req && !i_reg_we && hit) begin
        o_reg_rdata <= {24'h000000, stored} & `SWC_IMPL_MASK;
      end else if (i_reg_req) begin
        o_reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule

// [hdl/swc_regs.vh]
// Register offsets, field positions and reset values of the switch control register
// How it works
// - Writing one to full_reset_trigger starts a fundamental reset, zero does nothing, it reads 0.
// - Writing one to warm_reset_trigger starts a hot reset, zero does nothing, it reads 0.
// - While hold_in_reset is one the switch core except the SMBus side stays in reset.
// - An error in configuration-memory loading sets hold_in_reset, and loaded code may set it.
// - With write_lock_release one lock-protected fields take writes, with it zero they are read-only.
// - write_lock_release resets to zero but is set during any reset operation.
// - budget_value_write_enable opens the per-port power budget values and is lock-protected.
// - link_down_reset_mask stops an upstream DL_Down from causing a hot reset, other causes stay.
// - skip_load_on_warm_reset drops the configuration-memory step from the hot reset sequence.
// - force_strict_ordering makes the switch ignore the relaxed-ordering attribute.
// - Sticky fields keep their values across a hot reset.
`ifndef SWC_REGS_VH
`define SWC_REGS_VH

// ****************************************
// Address map
// ****************************************
`define SWC_ADDR_W            12
`define SWC_SWITCH_CONTROL    12'h404

// ****************************************
// Field positions
// ****************************************
`define SWC_FULL_RESET_BIT    0
`define SWC_WARM_RESET_BIT    1
`define SWC_HOLD_BIT          2
`define SWC_LOCK_REL_BIT      3
`define SWC_BUDGET_WE_BIT     4
`define SWC_LD_MASK_BIT       5
`define SWC_SKIP_LOAD_BIT     6
`define SWC_STRICT_BIT        7

// ****************************************
// Reset values and field attributes
// ****************************************
`define SWC_CTRL_RESET        8'h00
`define SWC_STICKY_MASK       8'hf8
`define SWC_LOCKED_MASK       8'h10
`define SWC_IMPL_MASK         32'h000000ff

`endif

// [hdl/swc_ctl_bit.v]
// One stored control bit with hardware set, lock gating and warm-reset clearing
`timescale 1ns/1ps
module swc_ctl_bit #(
  parameter STICKY    = 1,
  parameter LOCKED    = 0,
  parameter RESET_VAL = 1'b0
) (
  input  wire i_clock,
  input  wire i_rst,
  input  wire i_warm_rst,
  input  wire i_wr,
  input  wire i_wdata,
  input  wire i_unlock,
  input  wire i_hw_set,
  output reg  o_q
);

  reg next_q;

  always @* begin
    next_q = o_q;
    if (i_wr && (LOCKED == 0 || i_unlock)) begin
      next_q = i_wdata;
    end
    if (i_warm_rst && STICKY == 0) begin
      next_q = RESET_VAL[0];
    end
    // Hardware set is applied last so it beats any clear in the same cycle
    if (i_hw_set) begin
      next_q = 1'b1;
    end
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_q <= RESET_VAL[0];
    end else begin
      o_q <= next_q;
    end
  end

endmodule

// [hdl/swc_trigger.v]
// Reset request latch: held from its cause until the sequencer acknowledges it
`timescale 1ns/1ps
module swc_trigger (
  input  wire i_clock,
  input  wire i_rst,
  input  wire i_cause,
  input  wire i_ack,
  output reg  o_req
);

  // A cause in the acknowledge cycle starts a new request rather than being lost
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_req <= 1'b0;
    end else if (i_cause) begin
      o_req <= 1'b1;
    end else if (i_ack) begin
      o_req <= 1'b0;
    end
  end

endmodule

// [sim/swc_ctrl_sva.sv]
// Assertion checker for the switch control register
`timescale 1ns/1ps
module swc_ctrl_sva (
  input wire        i_clock,
  input wire        i_rst,
  input wire        i_reg_req,
  input wire        i_reg_we,
  input wire [11:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire        o_reg_ack,
  input wire [31:0] o_reg_rdata,
  input wire        i_reset_in_progress,
  input wire        o_full_reset_req,
  input wire        o_warm_reset_req,
  input wire        o_write_lock_release,
  input wire        o_budget_value_write_enable,
  input wire        o_force_strict_ordering
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire wr = i_reg_req && i_reg_we && i_reg_addr == 12'h404;
  a_ack_one_cycle:
    assert property (i_reg_req |=> o_reg_ack) else $error("ack late");
  a_trigger_reads_zero:
    assert property (o_reg_ack |-> o_reg_rdata[1:0] == 2'h0) else $error("trigger read");
  a_reserved_reads_zero:
    assert property (o_reg_ack |-> o_reg_rdata[31:8] == 24'h0) else $error("reserved read");
  a_full_req_set:
    assert property (wr && i_reg_wdata[0] |=> o_full_reset_req) else $error("full req");
  a_warm_req_set:
    assert property (wr && i_reg_wdata[1] |=> o_warm_reset_req) else $error("warm req");
  a_reset_unlocks:
    assert property (i_reset_in_progress |=> o_write_lock_release) else $error("unlock");
  a_budget_locked:
    assert property (!o_write_lock_release |=> $stable(o_budget_value_write_enable))
      else $error("budget moved");
  a_strict_written:
    assert property (wr |=> o_force_strict_ordering == $past(i_reg_wdata[7]))
      else $error("strict bit");
  c_full: cover property (wr && i_reg_wdata[0]);
  c_warm: cover property ($rose(o_warm_reset_req));
  c_unlock: cover property (i_reset_in_progress);
endmodule
bind swc_ctrl swc_ctrl_sva swc_ctrl_sva_i (.*);

// [sim/test_swc_ctrl.sv]
// Self-checking bench for the switch control register
`timescale 1ns/1ps
module test_swc_ctrl;
  logic        i_clock = 0, i_rst = 1, i_reg_req = 0, i_reg_we = 0, i_warm_rst = 0;
  logic        i_reset_in_progress = 0, i_load_error = 0, i_upstream_dl_down = 0;
  logic        i_other_warm_cause = 0, i_full_reset_ack = 0, i_warm_reset_ack = 0;
  logic [11:0] i_reg_addr = 12'h0;
  logic [31:0] i_reg_wdata = 32'h0;
  wire         o_reg_ack, o_full_reset_req, o_warm_reset_req, o_hold_in_reset;
  wire         o_write_lock_release, o_budget_value_write_enable;
  wire         o_skip_load_on_warm_reset, o_force_strict_ordering;
  wire  [31:0] o_reg_rdata;
  int          num_errors = 0, comparisons = 0, cycles = 0;
  swc_ctrl swc_ctrl_i (.*);
  initial forever #2 i_clock = ~i_clock;
  // Whole run is about 85 cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize;
    $display("counts: %0d mismatches, %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge i_clock);
    i_reg_req <= 1'h1;
    i_reg_we <= w;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_req <= 1'h0;
    #1 chk("ack", 32'h1, o_reg_ack);
  endtask
  task automatic wr(logic [31:0] d);
    acc(1'h1, 12'h404, d);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk("rdata", e, o_reg_rdata);
  endtask
  task automatic ack(logic [1:0] m);
    @(posedge i_clock);
    {i_warm_reset_ack, i_full_reset_ack} <= m;
    @(posedge i_clock);
    {i_warm_reset_ack, i_full_reset_ack} <= 2'h0;
    #1 chk("req", 32'h0, {o_warm_reset_req, o_full_reset_req});
  endtask
  task automatic t_lock;
    rd(12'h404, 32'h0);
    wr(32'h10);
    rd(12'h404, 32'h0);
    wr(32'h18);
    wr(32'h10);
    chk("budget", 32'h1, o_budget_value_write_enable);
    wr(32'h8);
    rd(12'h404, 32'h18);
    $display("done lock");
  endtask
  task automatic t_fields;
    wr(32'hffffffe4);
    rd(12'h404, 32'he4);
    chk("levels", 32'h7, {o_force_strict_ordering, o_skip_load_on_warm_reset, o_hold_in_reset});
    acc(1'h1, 12'h408, 32'hff);
    rd(12'h408, 32'h0);
    @(posedge i_clock);
    i_warm_rst <= 1'h1;
    @(posedge i_clock);
    @(posedge i_clock);
    i_warm_rst <= 1'h0;
    rd(12'h404, 32'he0);
    @(posedge i_clock);
    i_reset_in_progress <= 1'h1;
    @(posedge i_clock);
    i_reset_in_progress <= 1'h0;
    rd(12'h404, 32'he8);
    chk("unlock", 32'h1, o_write_lock_release);
    $display("done fields");
  endtask
  task automatic t_trig;
    @(posedge i_clock);
    i_upstream_dl_down <= 1'h1;
    @(posedge i_clock);
    @(posedge i_clock);
    i_other_warm_cause <= 1'h1;
    #1 chk("masked", 32'h0, o_warm_reset_req);
    @(posedge i_clock);
    i_other_warm_cause <= 1'h0;
    #1 chk("other", 32'h1, o_warm_reset_req);
    ack(2'h2);
    @(posedge i_clock);
    i_upstream_dl_down <= 1'h0;
    wr(32'hc0);
    @(posedge i_clock);
    i_upstream_dl_down <= 1'h1;
    @(posedge i_clock);
    @(posedge i_clock);
    #1 chk("link down", 32'h1, o_warm_reset_req);
    ack(2'h2);
    for (int i = 0; i < 2; i++) begin
      wr(32'h1 << i);
      chk("trigger", 32'h1 << i, {o_warm_reset_req, o_full_reset_req});
      rd(12'h404, 32'h0);
      ack(2'h1 << i);
    end
    wr(32'h0);
    chk("no trigger", 32'h0, {o_warm_reset_req, o_full_reset_req});
    @(posedge i_clock);
    i_load_error <= 1'h1;
    @(posedge i_clock);
    i_load_error <= 1'h0;
    #1 chk("hold", 32'h1, o_hold_in_reset);
    wr(32'h0);
    chk("hold off", 32'h0, o_hold_in_reset);
    $display("done triggers");
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'h0;
    t_lock();
    t_fields();
    t_trig();
    summarize();
  end
endmodule
